// File: core/pcsc_pkg.sv
// Purpose: Constants and types for the synthesizer calibration/sync control slice
// Assumes: Byte-wide registers, written through a staging copy and moved to
//          the active copy on a transfer strobe
// Notes:   Functional notes below
//
// Functional notes
// - Divider code 11 divides the reference by 16, the slowest calibration clock.
// - A calibration starts only on a 0-to-1 change of the active trigger bit.
// - The sync-mode field picks none (00/11), asynchronous (01) or synchronous (10) reset.
// - The status-pin enable bit divides the routed status signal by four.
// - The calibration clock is the reference clock divided by the selected ratio.
`default_nettype none

package pcsc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [9:0] OFS_LD_CAL     = 10'h018;
   localparam logic [9:0] OFS_SYNC_DELAY = 10'h019;
   localparam logic [9:0] OFS_STATUS_MON = 10'h01a;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_LD_CAL     = 8'h06;
   localparam logic [7:0] RST_SYNC_DELAY = 8'h00;
   localparam logic [7:0] RST_STATUS_MON = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CAL_NOW_BIT    = 0;
   localparam int CAL_DIV_LSB    = 1;
   localparam int SYNC_MODE_LSB  = 6;
   localparam int R_DELAY_LSB    = 3;
   localparam int N_DELAY_LSB    = 0;
   localparam int STAT_DIV4_BIT  = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Calibration divider codes and ratios
   localparam logic [1:0] CAL_DIV_CODE_A = 2'h0;
   localparam logic [1:0] CAL_DIV_CODE_B = 2'h1;
   localparam logic [1:0] CAL_DIV_CODE_8 = 2'h2;
   localparam logic [1:0] CAL_DIV_CODE_16 = 2'h3;
   localparam logic [4:0] CAL_RATIO_8    = 5'h08;
   localparam logic [4:0] CAL_RATIO_16   = 5'h10;

   ////////////////////////////////////////////////////////////////////////////
   // Sync pin modes
   typedef enum logic [1:0] {
      PCSC_SYNC_NONE  = 2'b00,
      PCSC_SYNC_ASYNC = 2'b01,
      PCSC_SYNC_SYNC  = 2'b10,
      PCSC_SYNC_NONE2 = 2'b11
   } pcsc_sync_mode_t;

   ////////////////////////////////////////////////////////////////////////////
   // Active control copy
   typedef struct packed {
      logic [1:0]      cal_div;
      logic            cal_now;
      pcsc_sync_mode_t sync_mode;
      logic [2:0]      r_delay;
      logic [2:0]      n_delay;
      logic            status_div4;
   } pcsc_active_t;

   localparam logic [1:0] STAT_DIV_LAST = 2'h3;

endpackage

`default_nettype wire

// File: core/pcsc_ctrl.sv
// Purpose: Calibration clock, calibration trigger, counter sync, path delay and
//          status-pin divider controls
// Assumes: Reference and status signals arrive as levels from another domain;
//          i_ref_clk is sampled and its rising edges used as enables
// Notes:   Register writes land in a staging copy; i_io_update moves them active
`default_nettype none

module pcsc_ctrl #(
   parameter logic [4:0]  CAL_RATIO_A = 5'h02,
   parameter logic [4:0]  CAL_RATIO_B = 5'h04,
   parameter logic [15:0] CAL_TICKS   = 16'h0100
) (
   // Clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_reset,
   // Register port
   input  wire logic       i_wr_en,
   input  wire logic [9:0] i_addr,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   input  wire logic       i_io_update,
   // Pins
   input  wire logic       i_ref_clk,
   input  wire logic       i_sync_n,
   input  wire logic       i_status_src,
   output logic            o_status_pin,
   // Synthesizer controls
   output logic            o_cal_tick,
   output logic            o_cal_start,
   output logic            o_cal_busy,
   output logic            o_ctr_rst_async,
   output logic            o_ctr_rst_sync,
   output logic      [2:0] o_r_delay,
   output logic      [2:0] o_n_delay
);

   ////////////////////////////////////////////////////////////////////////////
   // Staging and active registers
   logic [7:0]             stg_ld_cal_q;
   logic [7:0]             stg_sync_q;
   logic [7:0]             stg_stat_q;
   logic [7:0]             act_ld_cal_q;
   logic [7:0]             act_sync_q;
   logic [7:0]             act_stat_q;
   pcsc_pkg::pcsc_active_t act;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         stg_ld_cal_q <= pcsc_pkg::RST_LD_CAL;
         stg_sync_q   <= pcsc_pkg::RST_SYNC_DELAY;
         stg_stat_q   <= pcsc_pkg::RST_STATUS_MON;
      end else if (i_wr_en) begin
         case (i_addr)
            pcsc_pkg::OFS_LD_CAL:     stg_ld_cal_q <= i_wdata;
            pcsc_pkg::OFS_SYNC_DELAY: stg_sync_q   <= i_wdata;
            pcsc_pkg::OFS_STATUS_MON: stg_stat_q   <= i_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         act_ld_cal_q <= pcsc_pkg::RST_LD_CAL;
         act_sync_q   <= pcsc_pkg::RST_SYNC_DELAY;
         act_stat_q   <= pcsc_pkg::RST_STATUS_MON;
      end else if (i_io_update) begin
         act_ld_cal_q <= stg_ld_cal_q;
         act_sync_q   <= stg_sync_q;
         act_stat_q   <= stg_stat_q;
      end
   end

   always_comb begin
      act.cal_div     = act_ld_cal_q[pcsc_pkg::CAL_DIV_LSB +: 2];
      act.cal_now     = act_ld_cal_q[pcsc_pkg::CAL_NOW_BIT];
      act.sync_mode   = pcsc_pkg::pcsc_sync_mode_t'(act_sync_q[pcsc_pkg::SYNC_MODE_LSB +: 2]);
      act.r_delay     = act_sync_q[pcsc_pkg::R_DELAY_LSB +: 3];
      act.n_delay     = act_sync_q[pcsc_pkg::N_DELAY_LSB +: 3];
      act.status_div4 = act_stat_q[pcsc_pkg::STAT_DIV4_BIT];
   end

   // Reads return staged values, unmapped reads zero
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else begin
         case (i_addr)
            pcsc_pkg::OFS_LD_CAL:     o_rdata <= stg_ld_cal_q;
            pcsc_pkg::OFS_SYNC_DELAY: o_rdata <= stg_sync_q;
            pcsc_pkg::OFS_STATUS_MON: o_rdata <= stg_stat_q;
            default:                  o_rdata <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_r_delay <= 3'h0;
         o_n_delay <= 3'h0;
      end else begin
         o_r_delay <= act.r_delay;
         o_n_delay <= act.n_delay;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [2:0] ref_sq;
   logic [1:0] sync_sq;
   logic [2:0] stat_sq;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         ref_sq  <= 3'h0;
         sync_sq <= 2'h3;
         stat_sq <= 3'h0;
      end else begin
         ref_sq  <= {ref_sq[1:0], i_ref_clk};
         sync_sq <= {sync_sq[0], i_sync_n};
         stat_sq <= {stat_sq[1:0], i_status_src};
      end
   end

   logic ref_edge;
   logic stat_edge;
   assign ref_edge  = ref_sq[1] & ~ref_sq[2];
   assign stat_edge = stat_sq[1] & ~stat_sq[2];

   ////////////////////////////////////////////////////////////////////////////
   // Calibration clock divider
   logic [4:0] cal_ratio;
   logic [4:0] cal_cnt_q;

   always_comb begin
      case (act.cal_div)
         pcsc_pkg::CAL_DIV_CODE_A:  cal_ratio = CAL_RATIO_A;
         pcsc_pkg::CAL_DIV_CODE_B:  cal_ratio = CAL_RATIO_B;
         pcsc_pkg::CAL_DIV_CODE_8:  cal_ratio = pcsc_pkg::CAL_RATIO_8;
         // Code 11 is divide by 16
         pcsc_pkg::CAL_DIV_CODE_16: cal_ratio = pcsc_pkg::CAL_RATIO_16;
         default:                   cal_ratio = pcsc_pkg::CAL_RATIO_16;
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cal_cnt_q  <= 5'h00;
         o_cal_tick <= 1'b0;
      end else begin
         o_cal_tick <= 1'b0;
         if (ref_edge) begin
            if (cal_cnt_q >= cal_ratio - 5'h01) begin
               cal_cnt_q  <= 5'h00;
               o_cal_tick <= 1'b1;
            end else begin
               cal_cnt_q <= cal_cnt_q + 5'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Calibration trigger and run length
   logic        cal_now_prev_q;
   logic [15:0] cal_left_q;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cal_now_prev_q <= 1'b0;
         o_cal_start    <= 1'b0;
      end else begin
         cal_now_prev_q <= act.cal_now;
         o_cal_start    <= act.cal_now & ~cal_now_prev_q;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cal_left_q <= 16'h0000;
      end else if (o_cal_start) begin
         cal_left_q <= CAL_TICKS;
      end else if (o_cal_tick && cal_left_q != 16'h0000) begin
         cal_left_q <= cal_left_q - 16'h0001;
      end
   end

   assign o_cal_busy = (cal_left_q != 16'h0000);

   ////////////////////////////////////////////////////////////////////////////
   // Sync pin action on reference and prescaler counters
   logic sync_act;
   logic sync_act_prev_q;
   assign sync_act = ~sync_sq[1];

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         sync_act_prev_q <= 1'b0;
         o_ctr_rst_async <= 1'b0;
         o_ctr_rst_sync  <= 1'b0;
      end else begin
         sync_act_prev_q <= sync_act;
         o_ctr_rst_async <= sync_act && act.sync_mode == pcsc_pkg::PCSC_SYNC_ASYNC;
         o_ctr_rst_sync  <= sync_act && !sync_act_prev_q
                            && act.sync_mode == pcsc_pkg::PCSC_SYNC_SYNC;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status pin divide by four
   logic       stat_cnt_q;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         stat_cnt_q   <= 1'b0;
         o_status_pin <= 1'b0;
      end else if (!act.status_div4) begin
         stat_cnt_q   <= 1'b0;
         o_status_pin <= stat_sq[1];
      end else if (stat_edge) begin
         stat_cnt_q <= ~stat_cnt_q;
         if (stat_cnt_q) begin
            o_status_pin <= ~o_status_pin;
         end
      end
   end

endmodule

`default_nettype wire

// File: bench/pcsc_chk.sv
// Purpose: Port checker for pcsc_ctrl
// Assumes: One clock, reset active high
// Notes:   Bound from the bench top
`default_nettype none
module pcsc_chk (
   // Clock and reset
   input wire logic       i_clk_sys,
   input wire logic       i_reset,
   // Watched ports
   input wire logic       i_io_update,
   input wire logic       i_sync_n,
   input wire logic       o_cal_tick,
   input wire logic       o_cal_start,
   input wire logic       o_cal_busy,
   input wire logic       o_ctr_rst_async,
   input wire logic       o_ctr_rst_sync,
   input wire logic [2:0] o_r_delay,
   input wire logic [2:0] o_n_delay
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   /////////////////////////////////////////////////////////////////////////
   AST_START_ONE: assert property (o_cal_start |=> !o_cal_start)
      else $error("start pulse too long");
   AST_START_SRC: assert property (o_cal_start |-> $past(i_io_update, 2))
      else $error("start without strobe");
   AST_START_BUSY: assert property (o_cal_start |=> o_cal_busy)
      else $error("busy missing after start");
   AST_BUSY_SRC: assert property ($rose(o_cal_busy) |-> $past(o_cal_start))
      else $error("busy without start");
   AST_DLY_HOLD: assert property (!$past(i_io_update, 2) |->
      $stable({o_r_delay, o_n_delay})) else $error("delay moved without strobe");
   AST_ASYNC_SRC: assert property ($rose(o_ctr_rst_async) |-> !$past(i_sync_n, 2))
      else $error("async reset without pin");
   AST_SYNC_ONE: assert property (o_ctr_rst_sync |=> !o_ctr_rst_sync)
      else $error("sync reset pulse too long");
   AST_SYNC_SRC: assert property (o_ctr_rst_sync |-> !$past(i_sync_n, 2) &&
      !o_ctr_rst_async) else $error("sync reset bad cause");
   AST_TICK_GAP: assert property (o_cal_tick |=> !o_cal_tick [*3])
      else $error("cal ticks too close");
   COV_START: cover property (o_cal_start);
   COV_ASYNC: cover property ($rose(o_ctr_rst_async));
   COV_SYNC: cover property (o_ctr_rst_sync);
endmodule
`default_nettype wire

// File: bench/tb_pcsc_ctrl.sv
// Purpose: Self-checking bench for pcsc_ctrl
// Assumes: CAL_TICKS cut to 4
// Notes:   Ref and status sources are slow levels
`default_nettype none
module tb_pcsc_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic       i_clk_sys = 1'b0;
   logic       i_reset = 1'b1;
   logic       i_wr_en = 1'b0;
   logic [9:0] i_addr = 10'h000;
   logic [7:0] i_wdata = 8'h00;
   logic       i_io_update = 1'b0;
   logic       i_ref_clk = 1'b0;
   logic       i_sync_n = 1'b1;
   logic       i_status_src = 1'b0;
   logic [7:0] o_rdata;
   logic       o_status_pin, o_cal_tick, o_cal_start, o_cal_busy;
   logic       o_ctr_rst_async, o_ctr_rst_sync, st_q;
   logic [2:0] o_r_delay, o_n_delay;
   int         err_total, check_count, cyc, n_tick, n_start, n_async, n_sync, n_rise;

   pcsc_ctrl #(.CAL_TICKS(16'h0004)) i_pcsc_ctrl (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_wr_en(i_wr_en), .i_addr(i_addr),
      .i_wdata(i_wdata), .o_rdata(o_rdata), .i_io_update(i_io_update),
      .i_ref_clk(i_ref_clk), .i_sync_n(i_sync_n), .i_status_src(i_status_src),
      .o_status_pin(o_status_pin), .o_cal_tick(o_cal_tick), .o_cal_start(o_cal_start),
      .o_cal_busy(o_cal_busy), .o_ctr_rst_async(o_ctr_rst_async),
      .o_ctr_rst_sync(o_ctr_rst_sync), .o_r_delay(o_r_delay), .o_n_delay(o_n_delay));

   always #2 i_clk_sys = ~i_clk_sys;

   ////////////////////////////////////////////////////////////////////////////
   // Event counters and timeout
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      st_q <= o_status_pin;
      n_tick <= n_tick + int'(o_cal_tick);
      n_start <= n_start + int'(o_cal_start);
      n_async <= n_async + int'(o_ctr_rst_async);
      n_sync <= n_sync + int'(o_ctr_rst_sync);
      n_rise <= n_rise + int'(o_status_pin && !st_q);
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr_en <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(posedge i_clk_sys);
      i_addr <= a;
      repeat (2) @(posedge i_clk_sys);
      #1 chk(o_rdata, exp);
   endtask
   task automatic upd();
      @(posedge i_clk_sys);
      i_io_update <= 1'b1;
      @(posedge i_clk_sys);
      i_io_update <= 1'b0;
   endtask
   task automatic clr();
      #1 {n_tick, n_start, n_async, n_sync, n_rise} = '0;
   endtask
   task automatic toggle(input bit sel, input int n);
      repeat (2 * n) begin
         @(posedge i_clk_sys);
         if (sel) begin
            i_status_src <= ~i_status_src;
         end else begin
            i_ref_clk <= ~i_ref_clk;
         end
         @(posedge i_clk_sys);
      end
      repeat (8) @(posedge i_clk_sys);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      rd(10'h018, 8'h06);
      rd(10'h019, 8'h00);
      rd(10'h01a, 8'h00);
      wr(10'h020, 8'h5a);
      rd(10'h020, 8'h00);
      wr(10'h019, 8'h2b);
      rd(10'h019, 8'h2b);
      chk({2'h0, o_r_delay, o_n_delay}, 8'h00);
      upd();
      repeat (3) @(posedge i_clk_sys);
      #1 chk({2'h0, o_r_delay, o_n_delay}, 8'h2b);
      $display("test registers done");
      wr(10'h018, 8'h06);
      upd();
      clr();
      wr(10'h018, 8'h07);
      upd();
      repeat (4) @(posedge i_clk_sys);
      #1 chk({7'h00, o_cal_busy}, 8'h01);
      upd();
      repeat (4) @(posedge i_clk_sys);
      #1 chk(8'(n_start), 8'h01);
      for (int c = 0; c < 4; c++) begin
         wr(10'h018, 8'(c * 2));
         upd();
         clr();
         toggle(1'b0, 32);
         chk(8'(n_tick), 8'(32 >> (c + 1)));
      end
      chk({7'h00, o_cal_busy}, 8'h00);
      $display("test calibration done");
      for (int m = 0; m < 4; m++) begin
         wr(10'h019, 8'(m * 64));
         upd();
         repeat (4) @(posedge i_clk_sys);
         clr();
         @(posedge i_clk_sys);
         i_sync_n <= 1'b0;
         repeat (10) @(posedge i_clk_sys);
         i_sync_n <= 1'b1;
         repeat (10) @(posedge i_clk_sys);
         #1 chk(8'(n_sync), {7'h00, m == 2});
         chk({7'h00, n_async != 0}, {7'h00, m == 1});
      end
      $display("test sync done");
      for (int e = 0; e < 2; e++) begin
         wr(10'h01a, 8'(e * 128));
         upd();
         clr();
         toggle(1'b1, 8);
         chk(8'(n_rise), e ? 8'h02 : 8'h08);
      end
      $display("test status done");
      end_sim();
   end
endmodule

bind pcsc_ctrl pcsc_chk i_pcsc_chk (
   .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_io_update(i_io_update),
   .i_sync_n(i_sync_n), .o_cal_tick(o_cal_tick), .o_cal_start(o_cal_start),
   .o_cal_busy(o_cal_busy), .o_ctr_rst_async(o_ctr_rst_async),
   .o_ctr_rst_sync(o_ctr_rst_sync), .o_r_delay(o_r_delay), .o_n_delay(o_n_delay));
`default_nettype wire
